//--- inc/vidcr_consts.svh
/*
 * Constants of the regulator control bank: register pointers, reset values,
 * field positions, bit counts and timing figures.
 * Assumes nothing of the including file; the macros need no module context.
 */
`ifndef VIDCR_CONSTS_SVH
`define VIDCR_CONSTS_SVH

// Register pointers
`define VIDCR_PTR_CODE      8'h00
`define VIDCR_PTR_CTRL      8'h01

// Reset values: code 0110010 with its parity bit, control defaults
`define VIDCR_CODE_RESET    8'h32
`define VIDCR_CTRL_RESET    8'h09

// Control register field positions and implemented-bit mask
`define VIDCR_CTRL_SRC      7
`define VIDCR_CTRL_SUSP     4
`define VIDCR_CTRL_LLM      3
`define VIDCR_CTRL_PROT     0
`define VIDCR_CTRL_MASK     8'h99

// Voltage register parity position
`define VIDCR_CODE_PAR      7

// Bits per serial byte
`define VIDCR_BYTE_BITS     4'h8

// Clock period and protection hold time, in ns
`define VIDCR_CLK_NS        100
`define VIDCR_HOLD_NS       15000

`endif

//--- inc/vidcr_pkg.sv
/*
 * Types of the regulator control bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vidcr_pkg;

	// Serial protocol states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE      = 9'h001,
		ST_ADDR      = 9'h002,
		ST_ADDR_ACK  = 9'h004,
		ST_PTR       = 9'h008,
		ST_PTR_ACK   = 9'h010,
		ST_WDATA     = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA     = 9'h080,
		ST_RWAIT     = 9'h100
	} vidcr_state_type;

endpackage

//--- design/vidcr_bus_sense.sv
/*
 * Serial line sensing: edge pulses on the clock line, start and stop detect.
 * Assumes scl and sda already synchronous to clk; outputs other than sda_q are one-cycle pulses.
 */
`timescale 1ns/1ns
`default_nettype none

module vidcr_bus_sense (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Bus lines
	input  wire logic scl,
	input  wire logic sda,
	// Decoded events
	output logic      sda_q,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start_det,
	output logic      stop_det
);

	logic scl_q;
	logic scl_p;
	logic sda_p;

	////////////////////////////////////////////////////////////////////////
	// Two-deep history of both lines
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			scl_p <= 1'b1;
			sda_q <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_q <= scl;
			scl_p <= scl_q;
			sda_q <= sda;
			sda_p <= sda_q;
		end
	end

	// Data moving while the clock is high marks start or stop
	assign scl_rise  = scl_q & ~scl_p;
	assign scl_fall  = ~scl_q & scl_p;
	assign start_det = scl_q & scl_p & sda_p & ~sda_q;
	assign stop_det  = scl_q & scl_p & ~sda_p & sda_q;

endmodule

`default_nettype wire

//--- design/vidcr_top.sv
/*
 * Regulator control bank: two-wire serial slave holding the voltage code
 * register and the control register, with the settings driven out as levels.
 * Assumes scl and sda_in synchronous to ref_clk and far slower than it;
 * the pad combines sda_out and sda_oe into the open-drain wire.
 */
// Behaviour
// (RULE1) Voltage register holds 7-bit code in bits 6:0, reset 0110010.
// (RULE2) Control-source bit at 1 puts the stored code in charge of the output.
// (RULE3) Control-source bit resets to 0, external control.
// (RULE4) Writing 0 to control-source returns to external control at once.
// (RULE5) Suspend bit resets 0; at 1 protection is held off during code changes; the code holds it off only when control-source is also 1.
// (RULE6) Light-load select: 0 pulse-frequency, 1 pulse-width; resets to 1.
// (RULE7) Protection mode: 0 auto-recovery, 1 latch-off; resets to 1.
// (RULE8) Master sets bit 7 of voltage writes to XNOR of code bits.
// (RULE9) Voltage write with bad parity gets no acknowledge, code unchanged.
// (RULE10) Master should repeat the whole write after a parity rejection.
// (RULE11) Reading voltage register returns stored parity bit plus seven code bits.
// (RULE12) Invalid control write leaves the control register unchanged.
// (RULE13) Pointer 0 is voltage, 1 control; control bits 6,5,2,1 read zero.
// (RULE14) Parity is XNOR of code bits, checked before committing the byte.
// (RULE15) Own address after start is acknowledged low on the ninth clock.
// (RULE16) Foreign address: no acknowledge, ignore data, wait for next start.
// (RULE17) After eight read bits and a stop, return to idle regardless of ack.
// (RULE18) Written setting takes effect within 27 serial clocks of the start.
`timescale 1ns/1ns
`default_nettype none
`include "vidcr_consts.svh"

module vidcr_top
	import vidcr_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h2A  // arbitrary value
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// Serial bus
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Regulator settings
	output logic [6:0]      output_voltage_code,
	output logic            internal_mode,
	output logic            protection_suspend,
	output logic            light_load_mode_select,
	output logic            protection_mode,
	output logic            protection_hold
);

	localparam int HOLD_CYC = (`VIDCR_HOLD_NS + `VIDCR_CLK_NS - 1) / `VIDCR_CLK_NS;

	// Refuse settings the logic cannot serve
	if (SLAVE_ADDR == 7'h00) begin : g_chk
		$error("general call address cannot be the slave address");
	end
	if (HOLD_CYC > 255 || HOLD_CYC < 1) begin : g_chk_hold
		$error("hold count does not fit its counter");
	end

	// Voltage byte passes when bit 7 is the XNOR of bits 6:0
	function automatic logic par_ok(input logic [7:0] b);
		return b[`VIDCR_CODE_PAR] == ~(^b[6:0]);
	endfunction

	// Control byte passes only with reserved bits clear
	function automatic logic ctrl_ok(input logic [7:0] b);
		return (b & ~`VIDCR_CTRL_MASK) == 8'h00;
	endfunction

	logic            rst_m_r;
	logic            rst_n_s;
	logic            sda_q;
	logic            scl_rise;
	logic            scl_fall;
	logic            start_det;
	logic            stop_det;
	vidcr_state_type st_r;
	vidcr_state_type st_nxt;
	logic [3:0]      cnt_r;
	logic [3:0]      cnt_nxt;
	logic [7:0]      sh_r;
	logic [7:0]      sh_nxt;
	logic [7:0]      ptr_r;
	logic [7:0]      ptr_nxt;
	logic            oe_r;
	logic            oe_nxt;
	logic [7:0]      code_r;
	logic [7:0]      code_nxt;
	logic [7:0]      ctrl_r;
	logic [7:0]      ctrl_nxt;
	logic            code_commit;
	logic [7:0]      hold_cnt_r;
	logic [7:0]      hold_cnt_nxt;
	logic            hold_r;
	logic            hold_nxt;
	logic [7:0]      rd_byte;

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_m_r <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_s <= rst_m_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line events
	vidcr_bus_sense u_sense (
		.clk       (ref_clk),
		.rst_n     (rst_n_s),
		.scl       (scl),
		.sda       (sda_in),
		.sda_q     (sda_q),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// Read source for the addressed register; unmapped reads as zero
	always_comb begin
		case (ptr_r)
			`VIDCR_PTR_CODE: rd_byte = code_r;                     // [RULE11]
			`VIDCR_PTR_CTRL: rd_byte = ctrl_r & `VIDCR_CTRL_MASK;  // [RULE13]
			default:         rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Protocol engine and register writes
	always_comb begin
		st_nxt      = st_r;
		cnt_nxt     = cnt_r;
		sh_nxt      = sh_r;
		ptr_nxt     = ptr_r;
		oe_nxt      = oe_r;
		code_nxt    = code_r;
		ctrl_nxt    = ctrl_r;
		code_commit = 1'b0;
		if (start_det) begin
			st_nxt  = ST_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt  = 1'b0;
		end else if (stop_det) begin
			st_nxt = ST_IDLE;                                        // [RULE17]
			oe_nxt = 1'b0;
		end else begin
			case (st_r)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], sda_q};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `VIDCR_BYTE_BITS) begin
						if (st_r == ST_ADDR) begin
							if (sh_r[7:1] == SLAVE_ADDR) begin
								st_nxt = ST_ADDR_ACK;                       // [RULE15]
								oe_nxt = 1'b1;
								ptr_nxt = sh_r[0] ? ptr_r : ptr_r;
							end else begin
								st_nxt = ST_IDLE;                           // [RULE16]
							end
						end else if (st_r == ST_PTR) begin
							ptr_nxt = sh_r;
							st_nxt  = ST_PTR_ACK;
							oe_nxt  = 1'b1;
						end else if (ptr_r == `VIDCR_PTR_CODE && par_ok(sh_r)) begin
							code_nxt    = sh_r;                           // [RULE14] [RULE18]
							code_commit = 1'b1;
							st_nxt      = ST_WDATA_ACK;
							oe_nxt      = 1'b1;
						end else if (ptr_r == `VIDCR_PTR_CTRL && ctrl_ok(sh_r)) begin
							ctrl_nxt = sh_r & `VIDCR_CTRL_MASK;             // [RULE2] [RULE4]
							st_nxt   = ST_WDATA_ACK;
							oe_nxt   = 1'b1;
						end else begin
							st_nxt = ST_IDLE;                           // [RULE9] [RULE12]
						end
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						cnt_nxt = 4'h0;
						oe_nxt  = 1'b0;
						if (st_r != ST_ADDR_ACK) begin
							st_nxt = ST_WDATA;
						end else if (sh_r[0]) begin
							sh_nxt = rd_byte;
							oe_nxt = ~rd_byte[7];
							st_nxt = ST_RDATA;
						end else begin
							st_nxt = ST_PTR;
						end
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (cnt_r == `VIDCR_BYTE_BITS) begin
							oe_nxt = 1'b0;                                // [RULE17]
							st_nxt = ST_RWAIT;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = ~sh_r[6];
						end
					end
				end
				// Master ack ignored; only start or stop leaves here
				ST_RWAIT: st_nxt = ST_RWAIT;
				ST_IDLE:  st_nxt = ST_IDLE;
				default: begin
					st_nxt = ST_IDLE;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_r   <= ST_IDLE;
			cnt_r  <= 4'h0;
			sh_r   <= 8'h00;
			ptr_r  <= `VIDCR_PTR_CODE;
			oe_r   <= 1'b0;
			code_r <= `VIDCR_CODE_RESET;                              // [RULE1]
			ctrl_r <= `VIDCR_CTRL_RESET;                  // [RULE3] [RULE5] [RULE6] [RULE7]
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			sh_r   <= sh_nxt;
			ptr_r  <= ptr_nxt;
			oe_r   <= oe_nxt;
			code_r <= code_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protection hold while a new code settles; slew bound sets the length
	always_comb begin
		hold_cnt_nxt = hold_cnt_r;
		if (code_commit && ctrl_r[`VIDCR_CTRL_SUSP] && ctrl_r[`VIDCR_CTRL_SRC]) begin
			hold_cnt_nxt = 8'(HOLD_CYC);                              // [RULE5]
		end else if (hold_cnt_r != 8'h00) begin
			hold_cnt_nxt = hold_cnt_r - 8'h01;
		end
		hold_nxt = hold_cnt_nxt != 8'h00;
	end

	always_ff @(posedge ref_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			hold_cnt_r <= 8'h00;
			hold_r     <= 1'b0;
		end else begin
			hold_cnt_r <= hold_cnt_nxt;
			hold_r     <= hold_nxt;
		end
	end

	// Outputs straight from flops; pad drives only low
	assign sda_out                = 1'b0;
	assign sda_oe                 = oe_r;
	assign output_voltage_code    = code_r[6:0];
	assign internal_mode          = ctrl_r[`VIDCR_CTRL_SRC];
	assign protection_suspend     = ctrl_r[`VIDCR_CTRL_SUSP];
	assign light_load_mode_select = ctrl_r[`VIDCR_CTRL_LLM];
	assign protection_mode        = ctrl_r[`VIDCR_CTRL_PROT];
	assign protection_hold        = hold_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n_s);

	sequence s_byte_end(vidcr_state_type s);
		st_r == s && !start_det && !stop_det && scl_fall && cnt_r == `VIDCR_BYTE_BITS;
	endsequence

	AST_CODE_DEFAULT: assert property ($rose(rst_n_s) // [RULE1]
		|-> code_r == `VIDCR_CODE_RESET)
		else $error("voltage register not at default after reset");
	AST_CTRL_DEFAULT: assert property ($rose(rst_n_s) // [RULE3] [RULE6] [RULE7]
		|-> ctrl_r == `VIDCR_CTRL_RESET)
		else $error("control register not at default after reset");
	AST_PARITY_NACK: assert property (s_byte_end(ST_WDATA) // [RULE9]
		##0 (ptr_r == `VIDCR_PTR_CODE && !par_ok(sh_r))
		|=> !sda_oe && $stable(code_r) && st_r == ST_IDLE)
		else $error("bad parity byte was acknowledged or stored");
	AST_PARITY_ACK: assert property (s_byte_end(ST_WDATA) // [RULE14]
		##0 (ptr_r == `VIDCR_PTR_CODE && par_ok(sh_r))
		|=> sda_oe && code_r == $past(sh_r) ##1 sda_oe [*1])
		else $error("good parity byte not acknowledged and stored");
	AST_CTRL_KEEP: assert property (s_byte_end(ST_WDATA) // [RULE12]
		##0 (ptr_r == `VIDCR_PTR_CTRL && !ctrl_ok(sh_r))
		|=> $stable(ctrl_r) && !sda_oe)
		else $error("invalid control write changed the register");
	AST_SRC_CLEAR: assert property (s_byte_end(ST_WDATA) // [RULE4]
		##0 (ptr_r == `VIDCR_PTR_CTRL && sh_r == 8'h00)
		|=> !internal_mode && protection_mode == 1'b0)
		else $error("control-source bit not cleared by write of zero");
	// Scl low and high at least four cycles each, so the ack stands four cycles or more
	AST_ADDR_ACK: assert property (s_byte_end(ST_ADDR) ##0 sh_r[7:1] == SLAVE_ADDR // [RULE15]
		|=> (sda_oe && st_r == ST_ADDR_ACK) [*4])
		else $error("own address not acknowledged through ninth clock");
	AST_ADDR_MISS: assert property (s_byte_end(ST_ADDR) ##0 sh_r[7:1] != SLAVE_ADDR // [RULE16]
		|=> !sda_oe && st_r == ST_IDLE)
		else $error("foreign address acknowledged");
	AST_STOP_IDLE: assert property (stop_det && !start_det |=> st_r == ST_IDLE && !sda_oe) // [RULE17]
		else $error("stop did not return the engine to idle");
	AST_READ_PARITY: assert property ((st_r == ST_ADDR_ACK && scl_fall && sh_r[0] // [RULE11]
		&& ptr_r == `VIDCR_PTR_CODE && !start_det && !stop_det)
		|=> sda_oe == ~code_r[`VIDCR_CODE_PAR])
		else $error("read did not present stored parity bit first");
	AST_RESERVED_ZERO: assert property ((ctrl_r & ~`VIDCR_CTRL_MASK) == 8'h00) // [RULE13]
		else $error("reserved control bits not zero");

endmodule

`default_nettype wire

//--- dv/vidcr_bus_master.sv
/*
 * Behavioural two-wire bus master that drives the control bank.
 * Assumes the bench resolves sda_low into an open-drain wire with a pull-up; scl is driven both ways.
 */
`timescale 1ns/1ns
`default_nettype none

module vidcr_bus_master (
	// Clock
	input  wire logic clk,
	// Bus
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// Idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Five clocks per phase keeps scl low and high above the four-cycle minimum
	task automatic half();
		repeat (5) @(negedge clk);
	endtask

	// Start, also usable as a repeated start from scl low
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask

	// Stop from scl low
	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask

	// Eight bits out MSB first, ninth released; a released line reads the slave
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 8; i >= 0; i--) begin
			sda_low = (i > 0) ? ~d[i-1] : 1'b0;
			half();
			scl = 1'b1;
			half();
			if (i > 0)
				q[i-1] = sda;
			else
				a = sda;
			scl = 1'b0;
			half();
		end
		ack = ~a;
	endtask

	// Voltage byte; bad flips the parity on purpose
	function automatic logic [7:0] vbyte(input logic [6:0] c, input logic bad);
		return {(~^c) ^ bad, c};
	endfunction
endmodule

`default_nettype wire

//--- dv/vidcr_top_tb.sv
/*
 * Self-checking bench of the regulator control bank.
 * Assumes the bus master model; sda is open-drain with a pull-up.
 */
`timescale 1ns/1ns
`default_nettype none

module vidcr_top_tb;
	localparam logic [6:0] ADDR = 7'h15;  // arbitrary bus address
	logic        ref_clk, reset_n, m_scl, m_low, sda_oe, sda_out;
	logic        im, ps, llm, pm, hold, ehold, ok;
	logic [6:0]  code, ecode, c;
	logic [7:0]  ectrl, g, d;
	logic [11:0] exp_q[$], got_q[$];
	string       name_q[$];
	int          seed, mismatches, samples_checked, cycles;
	// Wire is low while either party pulls it
	wire         sda = ~(m_low | (sda_oe & ~sda_out));

	vidcr_top #(.SLAVE_ADDR(ADDR)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .scl(m_scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .output_voltage_code(code),
		.internal_mode(im), .protection_suspend(ps), .light_load_mode_select(llm),
		.protection_mode(pm), .protection_hold(hold));
	vidcr_bus_master m (.clk(ref_clk), .scl(m_scl), .sda_low(m_low), .sda(sda));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; a run of this size needs about 34000 cycles
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			give_verdict();
		end
	end

	// Watcher: oldest note against each result seen
	always @(negedge ref_clk) begin
		while (got_q.size() > 0) begin
			samples_checked++;
			if (got_q[0] !== exp_q[0]) begin
				mismatches++;
				$display("[FAIL] %s expected %h seen %h", name_q[0], exp_q[0], got_q[0]);
			end
			got_q.delete(0);
			exp_q.delete(0);
			name_q.delete(0);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic note(input string n, input logic [11:0] e, input logic [11:0] s);
		name_q.push_back(n);
		exp_q.push_back(e);
		got_q.push_back(s);
	endtask

	// Settings as levels: code, four control bits, hold
	task automatic chk_outs(input string n);
		note(n, {ecode, ectrl[7], ectrl[4], ectrl[3], ectrl[0], ehold},
			{code, im, ps, llm, pm, hold});
	endtask

	// Write: address, pointer, one data byte; settings looked at 27 serial clocks
	// of 15 cycles after the start condition, which lies 10 cycles before start() returns
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
		input logic [2:0] eack);
		logic [7:0] q;
		logic [2:0] k;
		m.start();
		fork
			begin
				m.xfer({a, 1'b0}, q, k[2]);
				m.xfer(p, q, k[1]);
				m.xfer(v, q, k[0]);
			end
			begin
				repeat (27 * 15 - 10) @(negedge ref_clk);
				chk_outs("settings");
			end
		join
		note("acks", {9'h000, eack}, {9'h000, k});
		m.stop();
	endtask

	// Read through repeated start, master nacks the byte
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		logic [7:0] q;
		logic       k;
		m.start();
		m.xfer({ADDR, 1'b0}, q, k);
		m.xfer(p, q, k);
		m.start();
		m.xfer({ADDR, 1'b1}, q, k);
		m.xfer(8'hFF, q, k);
		m.stop();
		note("read", {4'h0, e}, {4'h0, q});
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset_n = 1'b0;
		seed = 50;
		ehold = 1'b0;
		ecode = 7'h32;
		ectrl = 8'h09;
		repeat (4) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (6) @(negedge ref_clk);
		chk_outs("reset");
		rd(8'h00, {~^ecode, ecode});
		rd(8'h01, ectrl);
		$display("test reset done");
		// Corrupted parity refused, then the whole write repeated
		for (int i = 0; i < 4; i++) begin
			c = 7'($random(seed));
			wr(ADDR, 8'h00, m.vbyte(c, 1'b1), 3'b110);
			ecode = c;
			wr(ADDR, 8'h00, m.vbyte(c, 1'b0), 3'b111);
			rd(8'h00, {~^c, c});
		end
		$display("test voltage done");
		// Every control combination; reserved bits make a write fail
		for (int i = 0; i < 16; i++) begin
			g = {i[3] ^ 1'b1, 2'b00, i[2], i[1], 2'b00, i[0]};
			d = g | (8'($random(seed)) & 8'h66);
			ok = (d == g);
			if (ok)
				ectrl = g;
			wr(ADDR, 8'h01, d, {2'b11, ok});
			ectrl = g;
			wr(ADDR, 8'h01, g, 3'b111);
			rd(8'h01, g);
		end
		$display("test control done");
		// Foreign address ignored, own address still answered
		wr(ADDR ^ 7'h01, 8'h00, m.vbyte(~ecode, 1'b0), 3'b000);
		rd(8'h00, {~^ecode, ecode});
		$display("test foreign done");
		// Suspend with register control holds protection off for a while
		ectrl = 8'h90;
		wr(ADDR, 8'h01, ectrl, 3'b111);
		ecode = 7'h55;
		ehold = 1'b1;
		wr(ADDR, 8'h00, m.vbyte(ecode, 1'b0), 3'b111);
		repeat (200) @(negedge ref_clk);
		ehold = 1'b0;
		chk_outs("hold end");
		ectrl = 8'h80;
		wr(ADDR, 8'h01, ectrl, 3'b111);
		ecode = 7'h0F;
		wr(ADDR, 8'h00, m.vbyte(ecode, 1'b0), 3'b111);
		$display("test hold done");
		// Reset in mid-run puts every setting back to its default
		reset_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (6) @(negedge ref_clk);
		ecode = 7'h32;
		ectrl = 8'h09;
		chk_outs("reset again");
		rd(8'h01, ectrl);
		$display("test reset again done");
		repeat (2) @(posedge ref_clk);
		give_verdict();
	end
endmodule

`default_nettype wire
